// ==== rtl/mddr_core.sv ====
// Notes on behaviour
// - column command accepted every clock while the read buffer has room
// - four banks, 8192 rows, 512 columns, 32 bits
// - one double word per core clock
// - activate gives bank/row; column starts burst
// - no clock stop before init done
// - any valid command accepted after init
module mddr_core
  import mddr_pkg::*;
(
  // clock and reset
  input  wire logic     clock,
  input  wire logic     rst_n,
  // command bus
  input  wire logic     clk_en,
  input  wire cmd_bus_t cmd_in,
  // write data, one double word per clock
  input  wire logic     wr_valid,
  input  wire dword_t   wr_data,
  // read data toward the controller
  output logic          rd_valid,
  input  wire logic     rd_ready,
  output dword_t        rd_data,
  // status
  output logic          init_done,
  output logic          clock_stop_ok,
  output logic [12:0]   mode_std,
  output logic [12:0]   mode_ext,
  output logic [3:0]    open_banks
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  dword_t            mem [2**MEM_W];
  logic [ROW_W-1:0]  open_row [NUM_BANK];
  logic [COL_W-1:0]  burst_col;
  logic [BANK_W-1:0] burst_bank;
  logic              burst_wr;
  logic              burst_rd;

  init_state_t init_state;
  logic        std_loaded;
  logic        ext_loaded;
  logic [1:0]  ref_count;
  logic        cmd_live;
  logic        buf_ready;
  logic        rd_push;
  dword_t      rd_word;

  function automatic logic [MEM_W-1:0] mem_index(
    input logic [BANK_W-1:0] bank,
    input logic [ROW_W-1:0]  row,
    input logic [COL_W-1:0]  col
  );
    logic [ADDR_W-1:0] full;
    full      = {bank, row, col};
    mem_index = full[MEM_W-1:0];
  endfunction

  function automatic logic is_exec(input cmd_t c);
    is_exec = (c != CMD_NOP) && (c != CMD_CHIP_CMD_A);
  endfunction

  // commands count only with clock enable high and not stalled
  assign cmd_live      = clk_en && buf_ready;
  assign init_done     = (init_state == INIT_DONE);
  assign clock_stop_ok = init_done && !burst_wr && !burst_rd;

  // ----------------------------------------------------------------
  // initialization tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      init_state <= INIT_WAIT_PRE;
      std_loaded <= 1'b0;
      ext_loaded <= 1'b0;
      ref_count  <= 2'h0;
      mode_std   <= 13'h0000;
      mode_ext   <= 13'h0000;
    end
    else if (cmd_live)
    begin
      if (cmd_in.cmd == CMD_MODE_LOAD)
      begin
        if (cmd_in.bank == STD_MODE_BANK)
        begin
          mode_std   <= cmd_in.addr;
          std_loaded <= 1'b1;
        end
        else if (cmd_in.bank == EXT_MODE_BANK)
        begin
          mode_ext   <= cmd_in.addr;
          ext_loaded <= 1'b1;
        end
      end
      case (init_state)
        INIT_WAIT_PRE:
        begin
          if (cmd_in.cmd == CMD_PRECHARGE)
          begin
            init_state <= INIT_WAIT_REF;
          end
        end
        INIT_WAIT_REF, INIT_WAIT_MODES:
        begin
          if (cmd_in.cmd == CMD_REFRESH && ref_count != 2'h2)
          begin
            ref_count <= ref_count + 2'h1;
          end
          // either mode order; second refresh may follow them
          if ((ref_count == 2'h2 ||
               (ref_count == 2'h1 && cmd_in.cmd == CMD_REFRESH)) &&
              (std_loaded || (cmd_in.cmd == CMD_MODE_LOAD &&
                              cmd_in.bank == STD_MODE_BANK)) &&
              (ext_loaded || (cmd_in.cmd == CMD_MODE_LOAD &&
                              cmd_in.bank == EXT_MODE_BANK)))
          begin
            init_state <= INIT_DONE;
          end
          else if (cmd_in.cmd == CMD_MODE_LOAD)
          begin
            init_state <= INIT_WAIT_MODES;
          end
        end
        INIT_DONE:
        begin
          init_state <= INIT_DONE;
        end
        default:
        begin
          init_state <= INIT_WAIT_PRE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bank and burst control
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      open_banks <= 4'h0;
      burst_wr   <= 1'b0;
      burst_rd   <= 1'b0;
      burst_col  <= '0;
      burst_bank <= '0;
    end
    else if (cmd_live && init_done)
    begin
      burst_wr <= 1'b0;
      burst_rd <= 1'b0;
      case (cmd_in.cmd)
        CMD_ACTIVATE:
        begin
          open_banks[cmd_in.bank] <= 1'b1;
        end
        CMD_PRECHARGE:
        begin
          open_banks <= 4'h0;
        end
        CMD_READ, CMD_WRITE:
        begin
          // a new column command every clock
          burst_bank <= cmd_in.bank;
          burst_col  <= cmd_in.addr[COL_W-1:0];
          burst_wr   <= (cmd_in.cmd == CMD_WRITE);
          burst_rd   <= (cmd_in.cmd == CMD_READ) && open_banks[cmd_in.bank];
        end
        default:
        begin
          burst_col <= burst_col;
        end
      endcase
    end
    else if (buf_ready)
    begin
      burst_wr <= 1'b0;
      burst_rd <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (cmd_live && init_done && cmd_in.cmd == CMD_ACTIVATE &&
        is_exec(cmd_in.cmd))
    begin
      open_row[cmd_in.bank] <= cmd_in.addr;
    end
  end

  // ----------------------------------------------------------------
  // data path: one double word per clock in the core
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (burst_wr && wr_valid)
    begin
      mem[mem_index(burst_bank, open_row[burst_bank], burst_col)]
        <= wr_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rd_push <= 1'b0;
      rd_word <= '0;
    end
    else if (buf_ready)
    begin
      rd_push <= burst_rd;
      rd_word <= mem[mem_index(burst_bank, open_row[burst_bank],
                               burst_col)];
    end
  end

  mddr_skid u_skid (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (rd_push),
    .in_ready  (buf_ready),
    .in_data   (rd_word),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

endmodule // mddr_core

// ==== rtl/mddr_pkg.sv ====
package mddr_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned BANK_W   = 2;
  localparam int unsigned ROW_W    = 13;
  localparam int unsigned COL_W    = 9;
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned NUM_BANK = 4;
  localparam int unsigned ROWS     = 8192;
  localparam int unsigned COLS     = 512;
  localparam int unsigned MEM_W    = 14;
  localparam int unsigned ADDR_W   = BANK_W + ROW_W + COL_W;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned STARTUP_WAIT_US = 200;
  localparam int unsigned STARTUP_CYCLES  =
    (STARTUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_BURST_MAX = 8;
  localparam int unsigned MODE_LOAD_PERIOD  = 2;
  localparam logic [3:0]  MODE_WAIT_CNT     = 4'h2;

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_CHIP_CMD_A,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_MODE_LOAD
  } cmd_t;

  localparam logic [BANK_W-1:0] STD_MODE_BANK = 2'h0;
  localparam logic [BANK_W-1:0] EXT_MODE_BANK = 2'h2;

  typedef struct packed {
    cmd_t              cmd;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  addr;
  } cmd_bus_t;

  typedef struct packed {
    logic [WORD_W-1:0] hi;
    logic [WORD_W-1:0] lo;
  } dword_t;

  typedef enum {
    INIT_WAIT_PRE,
    INIT_WAIT_REF,
    INIT_WAIT_MODES,
    INIT_DONE
  } init_state_t;

endpackage

// ==== rtl/mddr_skid.sv ====
module mddr_skid
  import mddr_pkg::*;
(
  // clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // fill side
  input  wire logic   in_valid,
  output logic        in_ready,
  input  wire dword_t in_data,
  // drain side
  output logic        out_valid,
  input  wire logic   out_ready,
  output dword_t      out_data
);

  dword_t     slot [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot[rd_ptr];

  always_ff @(posedge clock)
  begin
    if (in_valid && in_ready)
    begin
      slot[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (out_valid && out_ready)
      begin
        rd_ptr <= ~rd_ptr;
      end
      case ({in_valid && in_ready, out_valid && out_ready})
        2'h2:    count <= count + 2'h1;
        2'h1:    count <= count - 2'h1;
        default: count <= count;
      endcase
    end
  end

endmodule // mddr_skid

// ==== tb/lpddr_cmd_timing_and_init_tb_top.sv ====
module lpddr_cmd_timing_and_init_tb_top
  import mddr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // harness and scenarios
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd_ready = 1'b0;
  logic        clk_en, wr_valid, rd_valid, init_done, clock_stop_ok;
  cmd_bus_t    cmd_in;
  dword_t      wr_data, rd_data;
  logic [12:0] mode_std, mode_ext;
  logic [3:0]  open_banks;
  int          err_count = 0;
  int          n_checks = 0;
  always #10 clock = ~clock;
  mddr_ctrl_model u_ctl (.clock, .clk_en, .cmd_in, .wr_valid, .wr_data);
  mddr_core uut (.clock, .rst_n, .clk_en, .cmd_in, .wr_valid, .wr_data,
    .rd_valid, .rd_ready, .rd_data, .init_done, .clock_stop_ok,
    .mode_std, .mode_ext, .open_banks);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic pop(input dword_t exp);
    int k;
    k = 0;
    while (rd_valid !== 1'b1 && k < 20)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    check(rd_valid, 1'b1);
    check(rd_data, exp);
    rd_ready = 1'b1;
    @(posedge clock);
    #1;
    rd_ready = 1'b0;
  endtask
  task automatic t_early;
    u_ctl.send(CMD_ACTIVATE, 2'h1, 13'h0011, 2);
    u_ctl.send(CMD_READ, 2'h1, 13'h0003, 4);
    check({init_done, open_banks, rd_valid}, 6'h00);
    check(clock_stop_ok, 1'b0);
    $display("t_early done");
  endtask
  task automatic t_init;
    int k;
    u_ctl.init_seq(13'h0032, 13'h0040);
    for (k = 0; k < 50 && init_done !== 1'b1; k++)
    begin
      @(posedge clock);
      #1;
    end
    check({init_done, clock_stop_ok}, 2'h3);
    check({mode_std, mode_ext}, {13'h0032, 13'h0040});
    $display("t_init done");
  endtask
  task automatic t_data;
    int b;
    for (b = 0; b < 4; b++)
      u_ctl.send(CMD_ACTIVATE, b[1:0], {11'h050, b[1:0]}, 2);
    check(open_banks, 4'hF);
    u_ctl.wr(2'h0, 13'h0005, 64'h0123_4567_89AB_CDEF);
    u_ctl.wr(2'h3, 13'h01FF, 64'hFEDC_BA98_7654_3210);
    u_ctl.send(CMD_READ, 2'h0, 13'h0005, 0);
    u_ctl.send(CMD_READ, 2'h3, 13'h01FF, 6);
    pop(64'h0123_4567_89AB_CDEF);
    pop(64'hFEDC_BA98_7654_3210);
    u_ctl.send(CMD_PRECHARGE, 2'h0, 13'h0400, 3);
    check(open_banks, 4'h0);
    u_ctl.send(CMD_READ, 2'h0, 13'h0005, 5);
    check(rd_valid, 1'b0);
    $display("t_data done");
  endtask
  task automatic t_gate;
    u_ctl.gate(CMD_ACTIVATE, 2'h2, 13'h0042);
    check(open_banks, 4'h0);
    u_ctl.gate(CMD_MODE_LOAD, STD_MODE_BANK, 13'h0011);
    check(mode_std, 13'h0032);
    $display("t_gate done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_count++;
    results();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check({init_done, open_banks, rd_valid, mode_std}, 19'h0);
    t_early();
    t_init();
    t_data();
    t_gate();
    results();
  end
endmodule // lpddr_cmd_timing_and_init_tb_top
bind mddr_core mddr_core_checker u_chk (.clock, .rst_n, .clk_en, .cmd_in,
  .rd_valid, .rd_ready, .rd_data, .init_done, .clock_stop_ok, .mode_std,
  .mode_ext, .open_banks);

// ==== tb/mddr_core_checker.sv ====
module mddr_core_checker
  import mddr_pkg::*;
(
  // watched ports
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire cmd_bus_t    cmd_in,
  input wire logic        rd_valid,
  input wire logic        rd_ready,
  input wire dword_t      rd_data,
  input wire logic        init_done,
  input wire logic        clock_stop_ok,
  input wire logic [12:0] mode_std,
  input wire logic [12:0] mode_ext,
  input wire logic [3:0]  open_banks
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic go = clk_en && !rd_valid;
  property p_noinit;
    !init_done |-> open_banks == 4'h0 && !rd_valid;
  endproperty
  a_noinit: assert property (p_noinit)
    else $error("early command used");
  property p_stop;
    clock_stop_ok |-> init_done;
  endproperty
  a_stop: assert property (p_stop)
    else $error("clock stop too early");
  property p_act;
    init_done && go && cmd_in.cmd == CMD_ACTIVATE
      |=> open_banks[$past(cmd_in.bank)];
  endproperty
  a_act: assert property (p_act) else $error("bank not opened");
  property p_pre;
    go && cmd_in.cmd == CMD_PRECHARGE |=> open_banks == 4'h0;
  endproperty
  a_pre: assert property (p_pre) else $error("banks left open");
  property p_std;
    go && cmd_in.cmd == CMD_MODE_LOAD && cmd_in.bank == STD_MODE_BANK
      |=> mode_std == $past(cmd_in.addr);
  endproperty
  a_std: assert property (p_std) else $error("std mode not loaded");
  property p_ext;
    go && cmd_in.cmd == CMD_MODE_LOAD && cmd_in.bank == EXT_MODE_BANK
      |=> mode_ext == $past(cmd_in.addr);
  endproperty
  a_ext: assert property (p_ext) else $error("ext mode not loaded");
  property p_rd;
    init_done && go && cmd_in.cmd == CMD_READ && open_banks[cmd_in.bank]
      |-> ##[2:3] rd_valid;
  endproperty
  a_rd: assert property (p_rd) else $error("read gave no word");
  property p_hold;
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("read word dropped");
  c_init: cover property ($rose(init_done));
  c_pop: cover property (rd_valid && rd_ready);
  c_b2b: cover property (cmd_in.cmd == CMD_READ ##1 cmd_in.cmd == CMD_READ);
  c_gate: cover property (!clk_en ##1 !clk_en);
endmodule // mddr_core_checker

// ==== tb/mddr_ctrl_model.sv ====
module mddr_ctrl_model
  import mddr_pkg::*;
(
  // command side
  input  wire logic clock,
  output logic      clk_en,
  output cmd_bus_t  cmd_in,
  output logic      wr_valid,
  output dword_t    wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // command driver, called just after a rising edge
  // ----------------------------------------------------------------
  initial
  begin
    clk_en   = 1'b1;
    cmd_in   = '{CMD_NOP, 2'h0, 13'h0000};
    wr_valid = 1'b0;
    wr_data  = '0;
  end
  // idle clocks after each command cover the rounded-up minima
  task automatic send(input cmd_t c, input logic [1:0] b,
                      input logic [12:0] a, input int gap);
    cmd_in = '{c, b, a};
    @(posedge clock);
    #1;
    if (gap != 0)
    begin
      cmd_in = '{CMD_NOP, ~b, ~a};
      repeat (gap) @(posedge clock);
      #1;
    end
  endtask
  task automatic wr(input logic [1:0] b, input logic [12:0] a,
                    input dword_t d);
    send(CMD_WRITE, b, a, 0);
    cmd_in   = '{CMD_NOP, ~b, ~a};
    wr_valid = 1'b1;
    wr_data  = d;
    @(posedge clock);
    #1;
    wr_valid = 1'b0;
    wr_data  = ~d;
    repeat (2) @(posedge clock);
    #1;
  endtask
  // clock enable held low for two clocks: the command on the bus is not
  // taken; a nop stands as clock enable comes back
  task automatic gate(input cmd_t c, input logic [1:0] b,
                      input logic [12:0] a);
    clk_en = 1'b0;
    cmd_in = '{c, b, a};
    repeat (2) @(posedge clock);
    #1;
    clk_en = 1'b1;
    cmd_in = '{CMD_NOP, ~b, ~a};
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic init_seq(input logic [12:0] ms, input logic [12:0] me);
    repeat (STARTUP_CYCLES) @(posedge clock);
    #1;
    send(CMD_PRECHARGE, 2'h0, 13'h0400, 2);
    send(CMD_REFRESH, 2'h0, 13'h0000, 5);
    send(CMD_MODE_LOAD, EXT_MODE_BANK, me, MODE_LOAD_PERIOD);
    send(CMD_MODE_LOAD, STD_MODE_BANK, ms, MODE_LOAD_PERIOD);
    send(CMD_REFRESH, 2'h0, 13'h0000, 5);
  endtask
endmodule // mddr_ctrl_model
